//--- common/rcs_defs.svh
// offsets, bit positions, reset values and vectors of the reset-cause block
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_OFF_CAUSE       8'h00
`define RCS_OFF_STATUS      8'h04
`define RCS_OFF_BROWN       8'h08
`define RCS_OFF_WDOG        8'h0C
`define RCS_OFF_IRQ_STAT    8'h10
`define RCS_OFF_IRQ_MASK    8'h14
`define RCS_OFF_CFG         8'h18

`define RCS_CAUSE_OVF       7
`define RCS_CAUSE_UNF       6
`define RCS_CAUSE_PIN       3
`define RCS_CAUSE_INSTR     2
`define RCS_CAUSE_PWR       1
`define RCS_CAUSE_BROWN     0
`define RCS_STATUS_TMO      4
`define RCS_STATUS_DOWN     3
`define RCS_BROWN_SWEN      7
`define RCS_BROWN_RDY       0
`define RCS_CFG_FAULTEN     0

`define RCS_IRQ_BOR         0
`define RCS_IRQ_PIN         1
`define RCS_IRQ_WDT_RST     2
`define RCS_IRQ_WDT_WAKE    3
`define RCS_IRQ_INT_WAKE    4
`define RCS_IRQ_INSTR       5
`define RCS_IRQ_OVF         6
`define RCS_IRQ_UNF         7

`define RCS_CAUSE_RST       8'h0C
`define RCS_STATUS_RST      8'h18
`define RCS_BROWN_RST       8'h80
`define RCS_WDOG_RST        8'h00
`define RCS_CFG_RST         8'h01
`define RCS_IRQ_MASK_RST    8'h00

`define RCS_CAUSE_WMASK     8'hCF
`define RCS_STATUS_WMASK    8'h07
`define RCS_BROWN_WMASK     8'h80
`define RCS_WDOG_WMASK      8'h3F
`define RCS_CFG_WMASK       8'h01

`define RCS_RESET_VEC       15'h0000
`define RCS_IRQ_VEC         15'h0004
`define RCS_PC_STEP         15'h0001

`endif

//--- common/rcs_pkg.sv
// types shared by the reset-cause block
package rcs_pkg;
  typedef logic [14:0] rcs_pc_t;

  typedef enum logic [3:0] {
    RCS_EV_NONE,
    RCS_EV_BOR,
    RCS_EV_PIN,
    RCS_EV_WDT_RST,
    RCS_EV_WDT_WAKE,
    RCS_EV_OVF,
    RCS_EV_UNF,
    RCS_EV_INSTR,
    RCS_EV_INT_WAKE
  } rcs_event_t;

  typedef enum logic [1:0] {
    RCS_SEQ_IDLE,
    RCS_SEQ_WAIT,
    RCS_SEQ_VECTOR
  } rcs_seq_t;
endpackage

//--- hw/rcs_pin_sync.sv
// two-stage synchroniser and falling-edge detector for the clear pin
module rcs_pin_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_n_i,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic fall_reg;

  // pin idles high through its pull-up, so reset to one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= pin_n_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      fall_reg <= last_reg & ~sync_reg;
    end
  end

  assign fall_o = fall_reg;
endmodule

//--- hw/rcs_top.sv
// reset-cause flags, program-counter redirection and register slave
//
// Behaviour
// - every reset updates cause flags or status
// - power-on gives flags 00 110x, status 1 1000
// - power-on always sets power-down flag
// - brown-out clears brown-out and stack flags
// - watchdog resets awake, wakes asleep
// - interrupt wake sets timeout, clears power-down
// - interrupt wake with interrupts enabled vectors after one instruction
// - pin reset clears pin flag, restarts
// - reset instruction clears its flag, restarts
// - enabled stack overflow sets bit 7, restarts
// - enabled stack underflow sets bit 6, restarts
// - pin and instruction flags: firmware sets, hardware clears
// - unimplemented bits read zero
// - stack faults reset only when enabled
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`include "rcs_defs.svh"

module rcs_top (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            hsel_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [2:0]      hsize_i,
  input  wire logic [31:0]     hwdata_i,
  input  wire logic            hready_i,
  output logic      [31:0]     hrdata_o,
  output logic                 hreadyout_o,
  output logic                 hresp_o,
  input  wire logic            bor_event_i,
  input  wire logic            wdt_timeout_i,
  input  wire logic            int_wake_i,
  input  wire logic            reset_instr_i,
  input  wire logic            stack_overflow_i,
  input  wire logic            stack_underflow_i,
  input  wire logic            master_clear_pin_n_i,
  input  wire logic            sleep_i,
  input  wire logic            global_irq_enable_i,
  input  wire logic            instr_done_i,
  input  wire logic            borrdy_i,
  input  wire rcs_pkg::rcs_pc_t pc_i,
  output logic                 core_reset_o,
  output logic                 pc_load_o,
  output rcs_pkg::rcs_pc_t     pc_value_o,
  output logic                 ret_push_o,
  output rcs_pkg::rcs_pc_t     ret_addr_o,
  output logic                 bor_sw_enable_o,
  output logic      [4:0]      wdt_prescale_o,
  output logic                 wdt_sw_enable_o,
  output logic                 irq_o
);
  import rcs_pkg::*;

  function automatic logic [7:0] rcs_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] mask);
    rcs_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic rcs_hit(input logic [7:0] addr, input logic [7:0] off);
    rcs_hit = (addr == off);
  endfunction

  logic [7:0]  cause_reg;
  logic [7:0]  cause_next;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  brown_reg;
  logic [7:0]  brown_next;
  logic [7:0]  wdog_reg;
  logic [7:0]  wdog_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic [7:0]  irq_stat_reg;
  logic [7:0]  irq_stat_next;
  logic [7:0]  irq_mask_reg;
  logic [7:0]  irq_mask_next;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        irq_reg;
  logic        core_reset_reg;
  logic        pc_load_reg;
  rcs_pc_t     pc_value_reg;
  logic        ret_push_reg;
  rcs_pc_t     ret_addr_reg;
  rcs_seq_t    seq_reg;
  rcs_seq_t    seq_next;
  logic        core_reset_next;
  logic        pc_load_next;
  rcs_pc_t     pc_value_next;
  logic        ret_push_next;
  rcs_pc_t     ret_addr_next;

  // bus decode
  wire        bus_take   = hsel_i & hready_i & htrans_i[1];
  wire        bus_rd     = bus_take & ~hwrite_i;
  wire [7:0]  rd_addr    = haddr_i[7:0];
  wire [7:0]  wdata8     = hwdata_i[7:0];
  wire        wr_cause   = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_CAUSE);
  wire        wr_status  = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_STATUS);
  wire        wr_brown   = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_BROWN);
  wire        wr_wdog    = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_WDOG);
  wire        wr_mask    = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_IRQ_MASK);
  wire        wr_cfg     = wr_pend_reg & rcs_hit(wr_addr_reg, `RCS_OFF_CFG);
  wire        rd_irq     = bus_rd & rcs_hit(rd_addr, `RCS_OFF_IRQ_STAT);

  // event qualification
  wire        pin_fall;
  wire        fault_en   = cfg_reg[`RCS_CFG_FAULTEN];
  wire        ev_ovf     = stack_overflow_i & fault_en;
  wire        ev_unf     = stack_underflow_i & fault_en;
  wire        ev_wdt_rst = wdt_timeout_i & ~sleep_i;
  wire        ev_wdt_wk  = wdt_timeout_i & sleep_i;
  wire        ev_int_wk  = int_wake_i & sleep_i;

  // one cause per cycle; the stronger reset wins
  wire rcs_event_t ev_sel =
    bor_event_i   ? RCS_EV_BOR      :
    pin_fall      ? RCS_EV_PIN      :
    ev_wdt_rst    ? RCS_EV_WDT_RST  :
    ev_wdt_wk     ? RCS_EV_WDT_WAKE :
    ev_ovf        ? RCS_EV_OVF      :
    ev_unf        ? RCS_EV_UNF      :
    reset_instr_i ? RCS_EV_INSTR    :
    ev_int_wk     ? RCS_EV_INT_WAKE : RCS_EV_NONE;

  wire [7:0] irq_set = {ev_unf, ev_ovf, reset_instr_i, ev_int_wk,
                        ev_wdt_wk, ev_wdt_rst, pin_fall, bor_event_i};

  // read data use next values, except the irq status register, so a write just before is seen
  wire [7:0] rd_byte =
    rcs_hit(rd_addr, `RCS_OFF_CAUSE)    ? cause_next    :
    rcs_hit(rd_addr, `RCS_OFF_STATUS)   ? status_next   :
    rcs_hit(rd_addr, `RCS_OFF_BROWN)    ? brown_next    :
    rcs_hit(rd_addr, `RCS_OFF_WDOG)     ? wdog_next     :
    rcs_hit(rd_addr, `RCS_OFF_IRQ_STAT) ? irq_stat_reg  :
    rcs_hit(rd_addr, `RCS_OFF_IRQ_MASK) ? irq_mask_next :
    rcs_hit(rd_addr, `RCS_OFF_CFG)      ? cfg_next      : 8'h00;

  rcs_pin_sync u_pin_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_n_i   (master_clear_pin_n_i),
    .fall_o    (pin_fall)
  );

  // cause flags: software write first, hardware event overrides it
  always_comb begin
    cause_next  = wr_cause ? rcs_merge(cause_reg, wdata8, `RCS_CAUSE_WMASK) : cause_reg;
    status_next = wr_status ? rcs_merge(status_reg, wdata8, `RCS_STATUS_WMASK) : status_reg;
    case (ev_sel)
      RCS_EV_BOR: begin
        cause_next[`RCS_CAUSE_OVF]    = 1'b0;
        cause_next[`RCS_CAUSE_UNF]    = 1'b0;
        cause_next[`RCS_CAUSE_PIN]    = 1'b1;
        cause_next[`RCS_CAUSE_INSTR]  = 1'b1;
        cause_next[`RCS_CAUSE_BROWN]  = 1'b0;
        status_next[`RCS_STATUS_TMO]  = 1'b1;
        status_next[`RCS_STATUS_DOWN] = 1'b1;
      end
      RCS_EV_PIN: begin
        cause_next[`RCS_CAUSE_PIN] = 1'b0;
        if (sleep_i) begin
          status_next[`RCS_STATUS_TMO]  = 1'b1;
          status_next[`RCS_STATUS_DOWN] = 1'b0;
        end
      end
      RCS_EV_WDT_RST: begin
        status_next[`RCS_STATUS_TMO] = 1'b0;
      end
      RCS_EV_WDT_WAKE: begin
        status_next[`RCS_STATUS_TMO]  = 1'b0;
        status_next[`RCS_STATUS_DOWN] = 1'b0;
      end
      RCS_EV_OVF: begin
        cause_next[`RCS_CAUSE_OVF] = 1'b1;
      end
      RCS_EV_UNF: begin
        cause_next[`RCS_CAUSE_UNF] = 1'b1;
      end
      RCS_EV_INSTR: begin
        cause_next[`RCS_CAUSE_INSTR] = 1'b0;
      end
      RCS_EV_INT_WAKE: begin
        status_next[`RCS_STATUS_TMO]  = 1'b1;
        status_next[`RCS_STATUS_DOWN] = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // control registers
  assign brown_next  = {wr_brown ? wdata8[`RCS_BROWN_SWEN] : brown_reg[`RCS_BROWN_SWEN],
                        6'h00, borrdy_i};
  assign wdog_next   = wr_wdog ? rcs_merge(wdog_reg, wdata8, `RCS_WDOG_WMASK) : wdog_reg;
  assign cfg_next    = wr_cfg ? rcs_merge(cfg_reg, wdata8, `RCS_CFG_WMASK) : cfg_reg;
  assign irq_mask_next = wr_mask ? wdata8 : irq_mask_reg;
  // a read clears only what it returned; a set in the same cycle survives
  assign irq_stat_next = (irq_stat_reg & ~(rd_irq ? irq_stat_reg : 8'h00)) | irq_set;

  // redirection of the program counter
  always_comb begin
    seq_next        = seq_reg;
    core_reset_next = 1'b0;
    pc_load_next    = 1'b0;
    pc_value_next   = pc_value_reg;
    ret_push_next   = 1'b0;
    ret_addr_next   = ret_addr_reg;
    case (ev_sel)
      RCS_EV_BOR, RCS_EV_PIN, RCS_EV_WDT_RST, RCS_EV_OVF, RCS_EV_UNF, RCS_EV_INSTR: begin
        core_reset_next = 1'b1;
        pc_load_next    = 1'b1;
        pc_value_next   = `RCS_RESET_VEC;
        seq_next        = RCS_SEQ_IDLE;
      end
      RCS_EV_WDT_WAKE: begin
        pc_load_next  = 1'b1;
        pc_value_next = pc_i + `RCS_PC_STEP;
        seq_next      = RCS_SEQ_IDLE;
      end
      RCS_EV_INT_WAKE: begin
        pc_load_next  = 1'b1;
        pc_value_next = pc_i + `RCS_PC_STEP;
        seq_next      = global_irq_enable_i ? RCS_SEQ_WAIT : RCS_SEQ_IDLE;
      end
      default: begin
        case (seq_reg)
          RCS_SEQ_IDLE: begin
          end
          RCS_SEQ_WAIT: begin
            // the instruction after the sleep runs before vectoring
            if (instr_done_i) begin
              seq_next = RCS_SEQ_VECTOR;
            end
          end
          RCS_SEQ_VECTOR: begin
            ret_push_next = 1'b1;
            ret_addr_next = pc_i;
            pc_load_next  = 1'b1;
            pc_value_next = `RCS_IRQ_VEC;
            seq_next      = RCS_SEQ_IDLE;
          end
          default: begin
            seq_next = RCS_SEQ_IDLE;
          end
        endcase
      end
    endcase
  end

  // power-on is the asynchronous reset itself
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cause_reg  <= `RCS_CAUSE_RST;
      status_reg <= `RCS_STATUS_RST;
    end else begin
      cause_reg  <= cause_next;
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brown_reg    <= `RCS_BROWN_RST;
      wdog_reg     <= `RCS_WDOG_RST;
      cfg_reg      <= `RCS_CFG_RST;
      irq_mask_reg <= `RCS_IRQ_MASK_RST;
      irq_stat_reg <= 8'h00;
      irq_reg      <= 1'b0;
    end else begin
      brown_reg    <= brown_next;
      wdog_reg     <= wdog_next;
      cfg_reg      <= cfg_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_next);
    end
  end

  // zero-wait slave: write data land one cycle after the address phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      wr_pend_reg   <= bus_take & hwrite_i;
      wr_addr_reg   <= bus_take ? haddr_i[7:0] : wr_addr_reg;
      hrdata_reg    <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_reg        <= RCS_SEQ_IDLE;
      core_reset_reg <= 1'b0;
      pc_load_reg    <= 1'b0;
      pc_value_reg   <= `RCS_RESET_VEC;
      ret_push_reg   <= 1'b0;
      ret_addr_reg   <= `RCS_RESET_VEC;
    end else begin
      seq_reg        <= seq_next;
      core_reset_reg <= core_reset_next;
      pc_load_reg    <= pc_load_next;
      pc_value_reg   <= pc_value_next;
      ret_push_reg   <= ret_push_next;
      ret_addr_reg   <= ret_addr_next;
    end
  end

  assign hrdata_o        = hrdata_reg;
  assign hreadyout_o     = hreadyout_reg;
  assign hresp_o         = 1'b0;
  assign irq_o           = irq_reg;
  assign core_reset_o    = core_reset_reg;
  assign pc_load_o       = pc_load_reg;
  assign pc_value_o      = pc_value_reg;
  assign ret_push_o      = ret_push_reg;
  assign ret_addr_o      = ret_addr_reg;
  assign bor_sw_enable_o = brown_reg[`RCS_BROWN_SWEN];
  assign wdt_prescale_o  = wdog_reg[5:1];
  assign wdt_sw_enable_o = wdog_reg[0];
endmodule

//--- verif/rcs_top_asserts.sv
// port-level checks for the reset-cause block
module rcs_top_asserts
  import rcs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        bor_event_i,
  input wire logic        wdt_timeout_i,
  input wire logic        reset_instr_i,
  input wire logic        sleep_i,
  input wire logic        instr_done_i,
  input wire rcs_pc_t     pc_i,
  input wire logic        core_reset_o,
  input wire logic        pc_load_o,
  input wire rcs_pc_t     pc_value_o,
  input wire logic        ret_push_o,
  input wire rcs_pc_t     ret_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  hresp_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
  ready_high_a: assert property ($past(reset_n_i) |-> hreadyout_o) else $error("wait state inserted");
  rd_idle_a: assert property (!$past(rd_take) |-> hrdata_o == 32'h0) else $error("read data outside read");
  flags_gap_a: assert property ($past(rd_take && haddr_i[7:0] == 8'h00) |-> hrdata_o[31:8] == 24'h000000
    && hrdata_o[5:4] == 2'b00) else $error("unused bits set");
  bor_pulse_a: assert property (bor_event_i |=> core_reset_o && pc_load_o && pc_value_o == 15'h0000) else $error("brown-out restart wrong");
  wake_pc_a: assert property (wdt_timeout_i && sleep_i && !bor_event_i |=> pc_load_o && !core_reset_o
    && pc_value_o == $past(pc_i) + 15'h0001) else $error("watchdog wake pc wrong");
  instr_restart_a: assert property (reset_instr_i && !(wdt_timeout_i && sleep_i) |=> core_reset_o
    && pc_value_o == 15'h0000) else $error("reset instruction restart wrong");
  reset_pc_a: assert property (core_reset_o |-> pc_load_o && pc_value_o == 15'h0000) else $error("reset pc wrong");
  vector_a: assert property (ret_push_o |-> pc_load_o && !core_reset_o && pc_value_o == 15'h0004) else $error("vector wrong");
  ret_order_a: assert property (ret_push_o |-> $past(instr_done_i, 2) && ret_addr_o == $past(pc_i))
    else $error("return push early or wrong");
endmodule

//--- verif/rcs_top_tb.sv
// self-checking bench for the reset-cause block
`include "rcs_defs.svh"
module rcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rcs_pkg::*;
  // flag, brown-out and watchdog register addresses
  localparam logic [7:0] flags_a = 8'h00;
  localparam logic [7:0] brown_a = 8'h08;
  localparam logic [7:0] wdog_a  = 8'h0C;
  logic clk_i, reset_n_i, hsel_i, hwrite_i, bor_event_i, wdt_timeout_i, int_wake_i, reset_instr_i;
  logic stack_overflow_i, stack_underflow_i, master_clear_pin_n_i, sleep_i, global_irq_enable_i;
  logic instr_done_i, borrdy_i, hreadyout_o, hresp_o, core_reset_o, pc_load_o, ret_push_o;
  logic bor_sw_enable_o, wdt_sw_enable_o, irq_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_seen;
  logic [1:0]  htrans_i;
  logic [4:0]  wdt_prescale_o;
  rcs_pc_t     pc_i, pc_value_o, ret_addr_o;
  logic [31:0] rd_q[$], pc_q[$];
  logic [7:0]  m_f, m_s, m_irq, w;
  logic        m_cfg;
  int          error_cnt, cmp_count, cyc;
  integer      seed = 32'h073eac36;
  event        rd_ev;
  // event index, asleep, interrupts enabled
  int          ev_n[13] = '{0, 2, 3, 4, 0, 1, 2, 1, 4, 4, 5, 6, 7};
  logic [12:0] ev_s = 13'h022C;
  logic [12:0] ev_g = 13'h0200;
  rcs_top dut_u (.*, .hready_i(hreadyout_o), .hsize_i(3'h2));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d, input logic [7:0] e);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    if (!wr) begin
      rd_q.push_back({24'h0, e});
      rd_seen = hrdata_o;
      -> rd_ev;
    end
  endtask
  task automatic fire(input int n, input logic s, input logic g);
    logic [14:0] pc;
    logic        ign;
    pc = 15'($random(seed));
    ign = (n == 4 && !s) || (n > 5 && !m_cfg);
    case (n)
      0: m_f = {6'b000011, m_f[1], 1'b0};
      1: m_f[3] = 1'b0;
      5: m_f[2] = 1'b0;
      6: m_f[7] = m_f[7] | m_cfg;
      7: m_f[6] = m_f[6] | m_cfg;
      default: ;
    endcase
    case (n)
      0: m_s[4:3] = 2'b11;
      1: if (s) m_s[4:3] = 2'b10;
      2: m_s[4] = 1'b0;
      3: m_s[4:3] = 2'b00;
      4: if (s) m_s[4:3] = 2'b10;
      default: ;
    endcase
    if (!ign) m_irq[n] = 1'b1;
    if (!ign) pc_q.push_back((n == 3 || n == 4) ? {2'b00, pc + 15'h0001, 15'h0} : {2'b10, 30'h0});
    if (!ign && n == 4 && g) pc_q.push_back({2'b01, 15'h0004, pc});
    sleep_i <= s;
    global_irq_enable_i <= g;
    pc_i <= pc;
    @(posedge clk_i);
    bor_event_i <= (n == 0);
    master_clear_pin_n_i <= (n != 1);
    wdt_timeout_i <= (n == 2 || n == 3);
    int_wake_i <= (n == 4);
    reset_instr_i <= (n == 5);
    stack_overflow_i <= (n == 6);
    stack_underflow_i <= (n == 7);
    @(posedge clk_i);
    {bor_event_i, wdt_timeout_i, int_wake_i, reset_instr_i, stack_overflow_i, stack_underflow_i} <= 6'h00;
    repeat (4) @(posedge clk_i);
    master_clear_pin_n_i <= 1'b1;
    // the vector waits for the instruction after the wake
    if (n == 4 && g) begin
      instr_done_i <= 1'b1;
      @(posedge clk_i);
      instr_done_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    bus(flags_a, 1'b0, 8'h00, m_f);
    bus(`RCS_OFF_STATUS, 1'b0, 8'h00, m_s);
  endtask
  always @(rd_ev) chk("hrdata", rd_q.pop_front(), rd_seen);
  // every pulse on the core side must match the oldest noted restart, wake or vector
  always @(posedge clk_i) begin
    if (reset_n_i && (pc_load_o | core_reset_o | ret_push_o) !== 1'b0)
      chk("pc_out", pc_q.size() ? pc_q.pop_front() : 32'hFFFFFFFF,
          {core_reset_o, ret_push_o, pc_value_o, ret_push_o ? ret_addr_o : 15'h0});
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {hsel_i, hwrite_i, bor_event_i, wdt_timeout_i, int_wake_i, reset_instr_i, instr_done_i} = '0;
    {stack_overflow_i, stack_underflow_i, sleep_i, global_irq_enable_i, haddr_i, hwdata_i, htrans_i, pc_i} = '0;
    master_clear_pin_n_i = 1'b1;
    borrdy_i = 1'b1;
    reset_n_i = 1'b0;
    m_cfg = 1'b1;
    m_irq = 8'h00;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    bus(flags_a, 1'b0, 8'h00, 8'h0C);
    bus(`RCS_OFF_STATUS, 1'b0, 8'h00, 8'h18);
    bus(brown_a, 1'b0, 8'h00, 8'h81);
    borrdy_i <= 1'b0;
    bus(brown_a, 1'b1, 8'h00, 8'h00);
    bus(brown_a, 1'b0, 8'h00, 8'h00);
    chk("bor_sw_enable", 32'h0, {31'h0, bor_sw_enable_o});
    bus(`RCS_OFF_CFG, 1'b0, 8'h00, 8'h01);
    bus(8'h1C, 1'b1, 8'hFF, 8'h00);
    bus(8'h1C, 1'b0, 8'h00, 8'h00);
    w = 8'($random(seed));
    bus(wdog_a, 1'b1, w, 8'h00);
    bus(wdog_a, 1'b0, 8'h00, w & 8'h3F);
    chk("wdt_ctrl_out", {26'h0, w[5:0]}, {26'h0, wdt_prescale_o, wdt_sw_enable_o});
    bus(flags_a, 1'b1, 8'hFF, 8'h00);
    bus(flags_a, 1'b0, 8'h00, 8'hCF);
    bus(`RCS_OFF_STATUS, 1'b1, 8'hFF, 8'h00);
    bus(`RCS_OFF_STATUS, 1'b0, 8'h00, 8'h1F);
    m_f = 8'hCF;
    m_s = 8'h1F;
    for (int i = 0; i < 13; i++) fire(ev_n[i], ev_s[i], ev_g[i]);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    bus(`RCS_OFF_IRQ_MASK, 1'b1, 8'hFF, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq_raised", 32'h1, {31'h0, irq_o});
    bus(`RCS_OFF_IRQ_STAT, 1'b0, 8'h00, m_irq);
    repeat (2) @(posedge clk_i);
    chk("irq_cleared", 32'h0, {31'h0, irq_o});
    bus(flags_a, 1'b1, 8'h00, 8'h00);
    bus(flags_a, 1'b0, 8'h00, 8'h00);
    m_f = 8'h00;
    bus(`RCS_OFF_CFG, 1'b1, 8'h00, 8'h00);
    m_cfg = 1'b0;
    fire(6, 1'b0, 1'b0);
    chk("pc_q_left", 32'h0, pc_q.size());
    // firmware marks both supply flags so the next power-on shows as zeros
    bus(flags_a, 1'b1, 8'h03, 8'h00);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    bus(flags_a, 1'b0, 8'h00, 8'h0C);
    bus(`RCS_OFF_STATUS, 1'b0, 8'h00, 8'h18);
    report_and_stop();
  end
endmodule
bind rcs_top rcs_top_asserts chk_u (.*);
